// *** tb/siodc_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module siodc_host (
    input wire logic CLK, // Bus clock
    output logic [15:0] ADDR, // Port address
    output logic [7:0] DATA_IN, // Write data
    output logic IO_READ_CMD, // Read strobe
    output logic IO_WRITE_CMD, // Write strobe
    output logic MEM_IO, // Memory or io
    output logic CYCLE_STATUS_1, // Status 1
    output logic CYCLE_STATUS_0 // Status 0
);
    initial begin
        ADDR = 16'h0000;
        DATA_IN = 8'h00;
        IO_READ_CMD = 1'b0;
        IO_WRITE_CMD = 1'b0;
        {MEM_IO, CYCLE_STATUS_1, CYCLE_STATUS_0} = 3'h3;
    end
    task automatic set_cycle(input logic [2:0] code);
        {MEM_IO, CYCLE_STATUS_1, CYCLE_STATUS_0} = code;
    endtask : set_cycle
    // Request held over exactly one sampling edge
    task automatic io_start(input logic wr, input logic [15:0] a,
                            input logic [7:0] d);
        ADDR = a;
        DATA_IN = d;
        IO_WRITE_CMD = wr;
        IO_READ_CMD = !wr;
        set_cycle(wr ? 3'h2 : 3'h1);
        @(posedge CLK);
        #2;
    endtask : io_start
    // Released bus shows inverted values, not the last ones
    task automatic io_end;
        ADDR = ~ADDR;
        DATA_IN = ~DATA_IN;
        IO_WRITE_CMD = 1'b0;
        IO_READ_CMD = 1'b0;
        set_cycle(3'h3);
        @(posedge CLK);
        #2;
    endtask : io_end
endmodule : siodc_host
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench;
    import siodc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cop_err = 1'b0, refresh = 1'b0;
    logic chan_chk = 1'b0, par_err = 1'b0, tmr2 = 1'b0, setup_en = 1'b0;
    logic fl_en = 1'b1, pp_en = 1'b1, s1_en = 1'b1, s2_en = 1'b1;
    logic pa_en = 1'b1, pb_en = 1'b1;
    logic [7:0] rtc_rd = 8'h5A, ext_rd = 8'hC3;
    wire [15:0] addr;
    wire [7:0] din, dout, rtc_idx, ctrl_a, ctrl_b;
    wire rd, wr, mio, st1, st0, dval, irq, busy, kbd, cop, pa, pb;
    wire fl, pp, s1, s2, rtc_sel, ext_sel, setup_sel, nmi;
    wire [2:0] ctype;
    wire [12:0] ext_addr;
    wire [7:0] sel = {kbd, cop, pa, pb, fl, pp, s1, s2};
    int errors = 0, checked = 0;
    logic [15:0] addr_t [0:12] = '{16'h0060, 16'h0064, 16'h00F8, 16'h00FF,
        16'h00F7, 16'h0300, 16'h0307, 16'h0308, 16'h0310, 16'h03F0,
        16'h0378, 16'h03F8, 16'h02F8};
    logic [7:0] exp_t [0:12] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'h00, 8'h20,
        8'h20, 8'h00, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
    always #25 clk = ~clk;
    siodc_host host (.CLK(clk), .ADDR(addr), .DATA_IN(din),
        .IO_READ_CMD(rd), .IO_WRITE_CMD(wr), .MEM_IO(mio),
        .CYCLE_STATUS_1(st1), .CYCLE_STATUS_0(st0));
    siodc_top dut (.CLK(clk), .SYS_RST(rst), .MEM_IO(mio),
        .CYCLE_STATUS_1(st1), .CYCLE_STATUS_0(st0), .ADDR(addr),
        .DATA_IN(din), .IO_READ_CMD(rd), .IO_WRITE_CMD(wr),
        .COPROC_ERROR(cop_err), .REFRESH(refresh),
        .BUS_CHANNEL_CHECK(chan_chk), .PARITY_ERROR(par_err),
        .TIMER2_OUT(tmr2), .SETUP_DATA_REG_ENABLE(setup_en),
        .FLOPPY_ENABLE(fl_en), .PARALLEL_ENABLE(pp_en),
        .SERIAL1_ENABLE(s1_en), .SERIAL2_ENABLE(s2_en),
        .PORT_A_ENABLE(pa_en), .PORT_A_BASE(16'h0300),
        .PORT_B_ENABLE(pb_en), .PORT_B_BASE(16'h0310),
        .RTC_READ_DATA(rtc_rd), .EXT_RAM_READ_DATA(ext_rd),
        .CYCLE_TYPE(ctype), .DATA_OUT(dout), .DATA_OUT_VALID(dval),
        .COPROC_ERROR_IRQ(irq), .COPROC_BUSY(busy), .KBD_CTRL_SELECT(kbd),
        .COPROC_SELECT(cop), .PROG_SELECT_A(pa), .PROG_SELECT_B(pb),
        .FLOPPY_SELECT(fl), .PARALLEL_SELECT(pp), .SERIAL1_SELECT(s1),
        .SERIAL2_SELECT(s2), .RTC_SELECT(rtc_sel), .RTC_INDEX(rtc_idx),
        .EXT_RAM_SELECT(ext_sel), .EXT_RAM_ADDRESS_BUS(ext_addr),
        .SETUP_DATA_SELECT(setup_sel), .CTRL_A(ctrl_a), .CTRL_B(ctrl_b),
        .NMI_REQUEST(nmi));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : cyc
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        host.io_start(1'b1, a, d);
        host.io_end();
    endtask : io_wr
    task automatic give_verdict;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        errors++;
        give_verdict();
    end
    initial begin
        cyc(20);
        rst = 1'b0;
        `CHK(ctype, 3'h3)
        for (int c = 0; c < 8; c++) begin
            host.set_cycle(3'(c));
            cyc(1);
            `CHK(ctype, 3'(c))
        end
        host.set_cycle(3'h3);
        refresh = 1'b1;
        cyc(1);
        refresh = 1'b0;
        cyc(1);
        `CHK(ctrl_b[4], 1'b1)
        refresh = 1'b1;
        cyc(1);
        refresh = 1'b0;
        cyc(1);
        `CHK(ctrl_b[4], 1'b0)
        for (int i = 0; i < 13; i++) begin
            host.io_start(1'b0, addr_t[i], 8'h00);
            `CHK(sel, exp_t[i])
            host.io_end();
            `CHK(sel, 8'h00)
        end
        host.io_start(1'b0, 16'h00F7, 8'h00);
        `CHK(dval, 1'b0)
        host.io_end();
        {pa_en, pb_en} = 2'h0;
        host.io_start(1'b0, 16'h0300, 8'h00);
        `CHK({pa, pb}, 2'h0)
        host.io_end();
        host.io_start(1'b0, 16'h0310, 8'h00);
        `CHK({pa, pb}, 2'h0)
        host.io_end();
        {fl_en, pp_en, s1_en, s2_en} = 4'h0;
        for (int i = 9; i < 13; i++) begin
            host.io_start(1'b0, addr_t[i], 8'h00);
            `CHK(sel[3:0], 4'h0)
            host.io_end();
        end
        cop_err = 1'b1;
        cyc(1);
        cop_err = 1'b0;
        cyc(2);
        `CHK({irq, busy}, 2'h3)
        io_wr(SIODC_COPROC_CLR, 8'h00);
        `CHK({irq, busy}, 2'h0)
        cop_err = 1'b1;
        host.io_start(1'b1, SIODC_COPROC_CLR, 8'h00);
        cop_err = 1'b0;
        host.io_end();
        `CHK({irq, busy}, 2'h3)
        io_wr(SIODC_COPROC_CLR, 8'h01);
        `CHK({irq, busy}, 2'h3)
        io_wr(SIODC_COPROC_CLR, 8'h00);
        `CHK({irq, busy}, 2'h0)
        io_wr(16'h0070, 8'h12);
        `CHK(rtc_idx, 8'h12)
        host.io_start(1'b0, 16'h0071, 8'h00);
        `CHK({rtc_sel, dval, dout}, {2'h3, 8'h5A})
        host.io_end();
        io_wr(16'h0074, 8'h33);
        `CHK(ext_addr, 13'h0000)
        io_wr(16'h0070, 8'h8D);
        io_wr(16'h0074, 8'hA5);
        io_wr(16'h0075, 8'hFF);
        `CHK(ext_addr, 13'h1FA5)
        host.io_start(1'b0, 16'h0076, 8'h00);
        `CHK({ext_sel, dval, dout}, {2'h3, 8'hC3})
        host.io_end();
        setup_en = 1'b1;
        host.io_start(1'b0, 16'h0700, 8'h00);
        `CHK(setup_sel, 1'b1)
        host.io_end();
        setup_en = 1'b0;
        host.io_start(1'b0, 16'h0700, 8'h00);
        `CHK(setup_sel, 1'b0)
        host.io_end();
        io_wr(16'h0092, 8'h5C);
        `CHK(ctrl_a, 8'h5C)
        host.io_start(1'b0, 16'h0092, 8'h00);
        `CHK({dval, dout}, {1'b1, 8'h5C})
        host.io_end();
        tmr2 = 1'b1;
        io_wr(16'h0061, 8'h0C);
        `CHK(ctrl_b[5:0], 6'h2C)
        host.io_start(1'b0, 16'h0061, 8'h00);
        `CHK({dval, dout}, {1'b1, 8'h2C})
        host.io_end();
        chan_chk = 1'b1;
        cyc(2);
        `CHK(nmi, 1'b0)
        io_wr(16'h0061, 8'h00);
        cyc(1);
        `CHK(nmi, 1'b1)
        `CHK(ctrl_b[7:6], 2'h1)
        chan_chk = 1'b0;
        io_wr(16'h0061, 8'h08);
        par_err = 1'b1;
        cyc(2);
        `CHK(nmi, 1'b1)
        `CHK(ctrl_b[7:6], 2'h2)
        io_wr(16'h0061, 8'h0C);
        cyc(1);
        `CHK(nmi, 1'b0)
        give_verdict();
    end
endmodule : testbench
`default_nettype wire

// *** verilog/siodc_pkg.sv ***
package siodc_pkg;
    // I/O port addresses, extended key and clear value
    localparam logic [15:0] SIODC_KBD_DATA = 16'h0060;
    localparam logic [15:0] SIODC_CTRL_B = 16'h0061;
    localparam logic [15:0] SIODC_KBD_CMD = 16'h0064;
    localparam logic [15:0] SIODC_RTC_INDEX = 16'h0070;
    localparam logic [15:0] SIODC_RTC_DATA = 16'h0071;
    localparam logic [15:0] SIODC_EXT_LOW = 16'h0074;
    localparam logic [15:0] SIODC_EXT_HIGH = 16'h0075;
    localparam logic [15:0] SIODC_EXT_DATA = 16'h0076;
    localparam logic [15:0] SIODC_CTRL_A = 16'h0092;
    localparam logic [15:0] SIODC_COPROC_CLR = 16'h00F0;
    localparam logic [15:0] SIODC_COPROC_BASE = 16'h00F8;
    localparam logic [15:0] SIODC_FLOPPY_BASE = 16'h03F0;
    localparam logic [15:0] SIODC_PAR_BASE = 16'h0378;
    localparam logic [15:0] SIODC_SER1_BASE = 16'h03F8;
    localparam logic [15:0] SIODC_SER2_BASE = 16'h02F8;
    localparam logic [7:0] SIODC_EXT_KEY = 8'h8D;
    localparam logic [7:0] SIODC_CLEAR_VALUE = 8'h00;
    // Control port B fields
    localparam int SIODC_B_TIMER_GATE = 0;
    localparam int SIODC_B_SPK_DATA = 1;
    localparam int SIODC_B_PARITY_DIS = 2;
    localparam int SIODC_B_CHAN_DIS = 3;
    localparam int SIODC_B_REFRESH = 4;
    localparam int SIODC_B_TIMER_OUT = 5;
    localparam int SIODC_B_CHAN_ERR = 6;
    localparam int SIODC_B_PARITY_ERR = 7;
    // Reset values
    localparam logic [7:0] SIODC_CTRL_B_RESET = 8'h00;
    localparam logic [7:0] SIODC_CTRL_A_RESET = 8'h00;
    localparam logic [7:0] SIODC_INDEX_RESET = 8'h00;
    localparam logic [3:0] SIODC_CYCLE_IDLE = 4'h3;
    typedef enum logic [2:0] {
        SIODC_INTA = 3'h0,
        SIODC_IO_RD = 3'h1,
        SIODC_IO_WR = 3'h2,
        SIODC_IO_NONE = 3'h3,
        SIODC_HALT = 3'h4,
        SIODC_MEM_RD = 3'h5,
        SIODC_MEM_WR = 3'h6,
        SIODC_MEM_NONE = 3'h7
    } siodc_cycle_type;
endpackage : siodc_pkg

// *** verilog/siodc_range_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
module siodc_range_decode
    import siodc_pkg::*;
#(
    parameter int DEPTH_BITS = 3
) (
    input wire logic [15:0] ADDR, // Port address
    input wire logic [15:0] BASE, // Range start, aligned
    input wire logic ENABLE, // Range enable
    input wire logic CMD, // I/O read or write active
    output logic HIT // Decoded select
);
    wire logic base_match;

    assign base_match = (ADDR[15:DEPTH_BITS] == BASE[15:DEPTH_BITS]);
    assign HIT = CMD && ENABLE && base_match;
endmodule : siodc_range_decode
`default_nettype wire

// *** verilog/siodc_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module siodc_top
    import siodc_pkg::*;
#(
    parameter int PROG_DEPTH_BITS = 3
) (
    input wire logic CLK, // 20 MHz clock
    input wire logic SYS_RST, // Sync reset, high
    input wire logic MEM_IO, // Memory/io status
    input wire logic CYCLE_STATUS_1, // Cycle status 1
    input wire logic CYCLE_STATUS_0, // Cycle status 0
    input wire logic [15:0] ADDR, // I/O address
    input wire logic [7:0] DATA_IN, // Write data
    input wire logic IO_READ_CMD, // I/O read strobe
    input wire logic IO_WRITE_CMD, // I/O write strobe
    input wire logic COPROC_ERROR, // Coprocessor error
    input wire logic REFRESH, // Refresh cycle pulse
    input wire logic BUS_CHANNEL_CHECK, // Channel check
    input wire logic PARITY_ERROR, // Memory parity error
    input wire logic TIMER2_OUT, // Timer 2 output
    input wire logic SETUP_DATA_REG_ENABLE, // Setup data enable
    input wire logic FLOPPY_ENABLE, // Option enable bits
    input wire logic PARALLEL_ENABLE, // Option enable
    input wire logic SERIAL1_ENABLE, // Option enable
    input wire logic SERIAL2_ENABLE, // Option enable
    input wire logic PORT_A_ENABLE, // Port A decode enable
    input wire logic [15:0] PORT_A_BASE, // Port A start
    input wire logic PORT_B_ENABLE, // Port B decode enable
    input wire logic [15:0] PORT_B_BASE, // Port B start
    input wire logic [7:0] RTC_READ_DATA, // RTC read data
    input wire logic [7:0] EXT_RAM_READ_DATA, // Ext RAM data
    output logic [2:0] CYCLE_TYPE, // Decoded cycle type
    output logic [7:0] DATA_OUT, // Read data
    output logic DATA_OUT_VALID, // Read data driven
    output logic COPROC_ERROR_IRQ, // Interrupt 13
    output logic COPROC_BUSY, // Busy to CPU
    output logic KBD_CTRL_SELECT, // Keyboard select
    output logic COPROC_SELECT, // Coprocessor select
    output logic PROG_SELECT_A, // Programmable select A
    output logic PROG_SELECT_B, // Programmable select B
    output logic FLOPPY_SELECT, // Floppy select
    output logic PARALLEL_SELECT, // Parallel select
    output logic SERIAL1_SELECT, // Serial 1 select
    output logic SERIAL2_SELECT, // Serial 2 select
    output logic RTC_SELECT, // RTC chip select
    output logic [7:0] RTC_INDEX, // RTC pointer
    output logic EXT_RAM_SELECT, // Ext RAM select
    output logic [12:0] EXT_RAM_ADDRESS_BUS, // Ext RAM address
    output logic SETUP_DATA_SELECT, // Setup data transfer
    output logic [7:0] CTRL_A, // Control port A
    output logic [7:0] CTRL_B, // Control port B
    output logic NMI_REQUEST // Non-maskable request
);
    logic [7:0] rtc_index;
    logic [7:0] ext_low;
    logic [7:0] ext_high;
    logic [7:0] ctrl_a;
    logic [3:0] ctrl_b_low;
    logic refresh_toggle;
    logic irq;
    logic busy;
    wire logic cmd;
    wire logic wr_cmd;
    wire logic ext_open;
    wire logic [7:0] ctrl_b_read;
    wire logic [7:0] next_data;
    wire logic next_valid;
    wire logic clear_write;
    wire logic kbd_hit;
    wire logic coproc_hit;
    wire logic hit_a;
    wire logic hit_b;
    wire logic hit_floppy;
    wire logic hit_par;
    wire logic hit_ser1;
    wire logic hit_ser2;
    wire logic ext_hit;
    wire logic next_nmi;

    function automatic logic is_port(input logic [15:0] a,
                                     input logic [15:0] p);
        is_port = (a == p);
    endfunction : is_port

    assign cmd = IO_READ_CMD || IO_WRITE_CMD;
    assign wr_cmd = IO_WRITE_CMD;
    assign ext_open = (rtc_index == SIODC_EXT_KEY);
    assign clear_write = wr_cmd && is_port(ADDR, SIODC_COPROC_CLR)
        && (DATA_IN == SIODC_CLEAR_VALUE);
    assign kbd_hit = cmd && (is_port(ADDR, SIODC_KBD_DATA)
        || is_port(ADDR, SIODC_KBD_CMD));
    assign coproc_hit = cmd
        && (ADDR[15:3] == SIODC_COPROC_BASE[15:3]);
    assign ext_hit = cmd && ext_open
        && (is_port(ADDR, SIODC_EXT_DATA));
    assign ctrl_b_read = {
        PARITY_ERROR && !ctrl_b_low[SIODC_B_PARITY_DIS],
        BUS_CHANNEL_CHECK && !ctrl_b_low[SIODC_B_CHAN_DIS],
        TIMER2_OUT,
        refresh_toggle,
        ctrl_b_low};
    assign next_nmi = (BUS_CHANNEL_CHECK
        && !ctrl_b_low[SIODC_B_CHAN_DIS])
        || (PARITY_ERROR && !ctrl_b_low[SIODC_B_PARITY_DIS]);
    assign next_valid = IO_READ_CMD && (is_port(ADDR, SIODC_CTRL_B)
        || is_port(ADDR, SIODC_CTRL_A)
        || is_port(ADDR, SIODC_RTC_INDEX)
        || is_port(ADDR, SIODC_RTC_DATA)
        || (ext_open && is_port(ADDR, SIODC_EXT_HIGH))
        || (ext_open && is_port(ADDR, SIODC_EXT_DATA)));
    assign next_data = is_port(ADDR, SIODC_CTRL_B) ? ctrl_b_read
        : is_port(ADDR, SIODC_CTRL_A) ? ctrl_a
        : is_port(ADDR, SIODC_RTC_INDEX) ? rtc_index
        : is_port(ADDR, SIODC_RTC_DATA) ? RTC_READ_DATA
        : is_port(ADDR, SIODC_EXT_HIGH) ? ext_high
        : is_port(ADDR, SIODC_EXT_DATA) ? EXT_RAM_READ_DATA
        : 8'h00;

    siodc_range_decode #(.DEPTH_BITS(PROG_DEPTH_BITS)) u_port_a (
        .ADDR(ADDR), .BASE(PORT_A_BASE), .ENABLE(PORT_A_ENABLE),
        .CMD(cmd), .HIT(hit_a));
    siodc_range_decode #(.DEPTH_BITS(PROG_DEPTH_BITS)) u_port_b (
        .ADDR(ADDR), .BASE(PORT_B_BASE), .ENABLE(PORT_B_ENABLE),
        .CMD(cmd), .HIT(hit_b));
    siodc_range_decode #(.DEPTH_BITS(3)) u_floppy (
        .ADDR(ADDR), .BASE(SIODC_FLOPPY_BASE), .ENABLE(FLOPPY_ENABLE),
        .CMD(cmd), .HIT(hit_floppy));
    siodc_range_decode #(.DEPTH_BITS(3)) u_par (
        .ADDR(ADDR), .BASE(SIODC_PAR_BASE), .ENABLE(PARALLEL_ENABLE),
        .CMD(cmd), .HIT(hit_par));
    siodc_range_decode #(.DEPTH_BITS(3)) u_ser1 (
        .ADDR(ADDR), .BASE(SIODC_SER1_BASE), .ENABLE(SERIAL1_ENABLE),
        .CMD(cmd), .HIT(hit_ser1));
    siodc_range_decode #(.DEPTH_BITS(3)) u_ser2 (
        .ADDR(ADDR), .BASE(SIODC_SER2_BASE), .ENABLE(SERIAL2_ENABLE),
        .CMD(cmd), .HIT(hit_ser2));

    // Coprocessor error latch, error wins over clear
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            irq <= 1'b0;
            busy <= 1'b0;
        end else if (COPROC_ERROR) begin
            irq <= 1'b1;
            busy <= 1'b1;
        end else if (clear_write) begin
            irq <= 1'b0;
            busy <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rtc_index <= SIODC_INDEX_RESET;
            ext_low <= 8'h00;
            ext_high <= 8'h00;
            ctrl_a <= SIODC_CTRL_A_RESET;
            ctrl_b_low <= SIODC_CTRL_B_RESET[3:0];
        end else if (wr_cmd) begin
            if (is_port(ADDR, SIODC_RTC_INDEX))
                rtc_index <= DATA_IN;
            if (ext_open && is_port(ADDR, SIODC_EXT_LOW))
                ext_low <= DATA_IN;
            if (ext_open && is_port(ADDR, SIODC_EXT_HIGH))
                ext_high <= DATA_IN;
            if (is_port(ADDR, SIODC_CTRL_A))
                ctrl_a <= DATA_IN;
            if (is_port(ADDR, SIODC_CTRL_B))
                ctrl_b_low <= DATA_IN[3:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST)
            refresh_toggle <= 1'b0;
        else if (REFRESH)
            refresh_toggle <= !refresh_toggle;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            CYCLE_TYPE <= SIODC_CYCLE_IDLE[2:0];
            DATA_OUT <= 8'h00;
            DATA_OUT_VALID <= 1'b0;
            KBD_CTRL_SELECT <= 1'b0;
            COPROC_SELECT <= 1'b0;
            PROG_SELECT_A <= 1'b0;
            PROG_SELECT_B <= 1'b0;
            FLOPPY_SELECT <= 1'b0;
            PARALLEL_SELECT <= 1'b0;
            SERIAL1_SELECT <= 1'b0;
            SERIAL2_SELECT <= 1'b0;
            RTC_SELECT <= 1'b0;
            EXT_RAM_SELECT <= 1'b0;
            SETUP_DATA_SELECT <= 1'b0;
            NMI_REQUEST <= 1'b0;
            CTRL_B <= SIODC_CTRL_B_RESET;
        end else begin
            CYCLE_TYPE <= {MEM_IO, CYCLE_STATUS_1, CYCLE_STATUS_0};
            DATA_OUT <= next_data;
            DATA_OUT_VALID <= next_valid;
            KBD_CTRL_SELECT <= kbd_hit;
            COPROC_SELECT <= coproc_hit;
            PROG_SELECT_A <= hit_a;
            PROG_SELECT_B <= hit_b;
            FLOPPY_SELECT <= hit_floppy;
            PARALLEL_SELECT <= hit_par;
            SERIAL1_SELECT <= hit_ser1;
            SERIAL2_SELECT <= hit_ser2;
            RTC_SELECT <= cmd && is_port(ADDR, SIODC_RTC_DATA);
            EXT_RAM_SELECT <= ext_hit;
            SETUP_DATA_SELECT <= cmd && SETUP_DATA_REG_ENABLE;
            NMI_REQUEST <= next_nmi;
            CTRL_B <= ctrl_b_read;
        end
    end

    assign COPROC_ERROR_IRQ = irq;
    assign COPROC_BUSY = busy;
    assign RTC_INDEX = rtc_index;
    assign EXT_RAM_ADDRESS_BUS = {ext_high[4:0], ext_low};
    assign CTRL_A = ctrl_a;

    irq_set_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        COPROC_ERROR |=> COPROC_ERROR_IRQ && COPROC_BUSY)
        else $error("error did not raise irq");
    busy_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        COPROC_BUSY && !clear_write |=> COPROC_BUSY)
        else $error("busy dropped without clear");
    irq_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        clear_write && !COPROC_ERROR |=> !COPROC_ERROR_IRQ && !COPROC_BUSY)
        else $error("clear did not drop irq");
    kbd_sel_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        IO_READ_CMD && ADDR == SIODC_KBD_CMD |=> KBD_CTRL_SELECT)
        else $error("keyboard select missing");
    kbd_data_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        cmd && ADDR == SIODC_KBD_DATA |=> KBD_CTRL_SELECT)
        else $error("keyboard data select missing");
    kbd_only_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        ADDR != SIODC_KBD_DATA && ADDR != SIODC_KBD_CMD |=> !KBD_CTRL_SELECT)
        else $error("keyboard select on foreign port");
    coproc_sel_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        cmd && ADDR == 16'h00FF |=> COPROC_SELECT)
        else $error("coprocessor select missing");
    coproc_only_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        ADDR[15:3] != SIODC_COPROC_BASE[15:3] |=> !COPROC_SELECT)
        else $error("coprocessor select out of range");
    prog_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !PORT_A_ENABLE |=> !PROG_SELECT_A)
        else $error("port A select while disabled");
    option_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !FLOPPY_ENABLE |=> !FLOPPY_SELECT)
        else $error("floppy select without enable");
    option_par_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !PARALLEL_ENABLE |=> !PARALLEL_SELECT)
        else $error("parallel select without enable");
    option_ser_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !SERIAL1_ENABLE && !SERIAL2_ENABLE
        |=> !SERIAL1_SELECT && !SERIAL2_SELECT)
        else $error("serial select without enable");
    cycle_type_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        1'b1 |=> CYCLE_TYPE == {$past(MEM_IO), $past(CYCLE_STATUS_1),
        $past(CYCLE_STATUS_0)})
        else $error("cycle type mismatch");
    rtc_data_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        IO_READ_CMD && ADDR == SIODC_RTC_DATA
        |=> DATA_OUT_VALID && DATA_OUT == $past(RTC_READ_DATA))
        else $error("clock data read mismatch");
    ext_lock_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        rtc_index != SIODC_EXT_KEY |=> !EXT_RAM_SELECT)
        else $error("extended port open without key");
    ext_addr_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_cmd && ext_open && ADDR == SIODC_EXT_HIGH
        |=> EXT_RAM_ADDRESS_BUS[12:8] == $past(DATA_IN[4:0]))
        else $error("extended high address not loaded");
    ctrl_a_read_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        IO_READ_CMD && ADDR == SIODC_CTRL_A
        |=> DATA_OUT_VALID && DATA_OUT == $past(ctrl_a))
        else $error("control A read mismatch");
    setup_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !SETUP_DATA_REG_ENABLE |=> !SETUP_DATA_SELECT)
        else $error("setup select without enable");
    nmi_chan_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        BUS_CHANNEL_CHECK && !ctrl_b_low[SIODC_B_CHAN_DIS] |=> NMI_REQUEST)
        else $error("channel check not reported");
    nmi_par_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        PARITY_ERROR && !ctrl_b_low[SIODC_B_PARITY_DIS] |=> NMI_REQUEST)
        else $error("parity error not reported");
    sel_drop_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !cmd |=> !KBD_CTRL_SELECT && !COPROC_SELECT && !RTC_SELECT)
        else $error("select held after command");
    toggle_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        REFRESH |=> ##1 CTRL_B[SIODC_B_REFRESH]
        != $past(CTRL_B[SIODC_B_REFRESH]))
        else $error("refresh toggle stuck");
endmodule : siodc_top
`default_nettype wire
